/* design/hps_seq_top.sv */
/*
 * hps_seq_top: host sequencer for power, pin release, configuration, clocks and shutdown.
 * Assumes a 20 MHz clock, a command port whose ready ends a bus transaction,
 * and supply-good and bus pins arriving asynchronously.
 */
// What this block does
// - shutdown pin released only after supplies good
// - wait 100 us after supply stable
// - keep supplies 10 ms after shutdown
// - immediate shutdown field shortens wait to 100us
// - 100 ms off before next power-up
// - slow supply ramp: software reset first
// - 2 ms silence after release or reset
// - address pin high: bus idle at release
// - configure channels, enable, power up E0
// - 10 ms after clocks before diagnostics
// - 44.1 kHz frame, ratio 256, TDM
`timescale 1ns/100ps
module hps_seq_top #(
	parameter int INIT_CYC = hps_pkg::T_INIT_CYC,
	parameter int WAKE_CYC = hps_pkg::T_WAKE_CYC,
	parameter int PD_CYC   = hps_pkg::T_PD_CYC,
	parameter int OFF_CYC  = hps_pkg::T_OFF_CYC,
	parameter int BIAS_CYC = hps_pkg::T_BIAS_CYC
) (
	input  wire logic             CLK_I,
	input  wire logic             RESETN_I,
	input  wire logic             START_I,
	input  wire logic             STOP_I,
	input  wire logic             SLOW_RAMP_I,
	input  wire logic [1:0]       SHDN_CFG_I,
	input  wire logic             SUPPLY_OK_I,
	input  wire logic             ADDR_HIGH_I,
	input  wire logic             SCL_I,
	input  wire logic             SDA_I,
	input  wire logic             CMD_READY_I,
	output logic                  SUPPLY_EN_O,
	output logic                  SHUTDOWN_N_O,
	output logic                  CMD_VALID_O,
	output hps_pkg::hps_cmd_t     CMD_O,
	output logic                  CLOCKS_EN_O,
	output logic                  RUNNING_O
);
	localparam int SUPPLY_CYC  = hps_pkg::T_SUPPLY_CYC;
	localparam int PD_FAST_CYC = hps_pkg::T_PD_FAST_CYC;
	hps_pkg::hps_state_t state_reg;
	hps_pkg::hps_state_t state_next;
	logic [31:0]         timer_reg;
	logic [31:0]         timer_load;
	logic [2:0]          idx_reg;
	logic [2:0]          idx_next;
	logic                supply_ok_s;
	logic                addr_high_s;
	logic                scl_s;
	logic                sda_s;
	logic                accept;
	logic                timer_done;
	logic                fast_pdn;
	hps_pkg::hps_cmd_t   cmd_next;
	logic [31:0]         since_ok_reg;
	logic [31:0]         since_rel_reg;
	logic [31:0]         since_shdn_reg;
	logic [31:0]         since_off_reg;
	logic [31:0]         since_clk_reg;
	hps_sync3 u_sync_ok   (.clk_i(CLK_I), .resetn_i(RESETN_I), .d_i(SUPPLY_OK_I), .q_o(supply_ok_s));
	hps_sync3 u_sync_addr (.clk_i(CLK_I), .resetn_i(RESETN_I), .d_i(ADDR_HIGH_I), .q_o(addr_high_s));
	hps_sync3 #(.RESET_VAL(1'b1)) u_sync_scl (.clk_i(CLK_I), .resetn_i(RESETN_I), .d_i(SCL_I),
		.q_o(scl_s));
	hps_sync3 #(.RESET_VAL(1'b1)) u_sync_sda (.clk_i(CLK_I), .resetn_i(RESETN_I), .d_i(SDA_I),
		.q_o(sda_s));
	assign accept     = CMD_VALID_O && CMD_READY_I;
	assign timer_done = (timer_reg == 32'h0000_0000);
	assign fast_pdn   = (SHDN_CFG_I == hps_pkg::SHDN_CFG_IMMEDIATE);
	always_comb begin
		state_next = state_reg;
		idx_next   = idx_reg;
		case (state_reg)
			hps_pkg::ST_OFF: if (START_I) begin
				state_next = hps_pkg::ST_PWR;
			end
			hps_pkg::ST_PWR: if (supply_ok_s) begin
				state_next = hps_pkg::ST_SETTLE;
			end
			hps_pkg::ST_SETTLE: begin
				if (!supply_ok_s) begin
					state_next = hps_pkg::ST_PWR;
				end else if (timer_done) begin
					state_next = hps_pkg::ST_BUSIDLE;
				end
			end
			hps_pkg::ST_BUSIDLE: begin
				if (!supply_ok_s) begin
					state_next = hps_pkg::ST_PWR;
				end else if (!addr_high_s || (scl_s && sda_s)) begin
					state_next = hps_pkg::ST_INIT;
				end
			end
			hps_pkg::ST_INIT: if (timer_done) begin
				state_next = SLOW_RAMP_I ? hps_pkg::ST_SWRST : hps_pkg::ST_WAKE;
			end
			hps_pkg::ST_SWRST: if (accept) begin
				state_next = hps_pkg::ST_SWRST_W;
			end
			hps_pkg::ST_SWRST_W: if (timer_done) begin
				state_next = hps_pkg::ST_WAKE;
			end
			hps_pkg::ST_WAKE: if (accept) begin
				state_next = hps_pkg::ST_WAKE_W;
			end
			hps_pkg::ST_WAKE_W: if (timer_done) begin
				state_next = hps_pkg::ST_CFG;
				idx_next   = 3'h0;
			end
			hps_pkg::ST_CFG: begin
				if (accept) begin
					if (idx_reg == 3'(hps_pkg::CFG_LEN - 1)) begin
						state_next = hps_pkg::ST_BIAS;
					end else begin
						idx_next = idx_reg + 3'h1;
					end
				end
			end
			hps_pkg::ST_BIAS: if (timer_done) begin
				state_next = hps_pkg::ST_DIAG;
			end
			hps_pkg::ST_DIAG: if (accept) begin
				state_next = hps_pkg::ST_RUN;
			end
			hps_pkg::ST_RUN: state_next = hps_pkg::ST_RUN;
			hps_pkg::ST_PDN: if (timer_done) begin
				state_next = hps_pkg::ST_GAP;
			end
			hps_pkg::ST_GAP: if (timer_done) begin
				state_next = hps_pkg::ST_OFF;
			end
			default: begin
				state_next = hps_pkg::ST_OFF;
			end
		endcase
		// stop waits for any pending bus command to finish
		if (STOP_I && !CMD_VALID_O) begin
			if (state_reg == hps_pkg::ST_PWR || state_reg == hps_pkg::ST_SETTLE ||
				state_reg == hps_pkg::ST_BUSIDLE) begin
				state_next = hps_pkg::ST_GAP;
			end else if (state_reg != hps_pkg::ST_OFF && state_reg != hps_pkg::ST_PDN &&
				state_reg != hps_pkg::ST_GAP) begin
				state_next = hps_pkg::ST_PDN;
			end
		end
	end

	always_comb begin
		case (state_next)
			hps_pkg::ST_SETTLE:  timer_load = 32'(SUPPLY_CYC);
			hps_pkg::ST_INIT:    timer_load = 32'(INIT_CYC);
			hps_pkg::ST_SWRST_W: timer_load = 32'(INIT_CYC);
			hps_pkg::ST_WAKE_W:  timer_load = 32'(WAKE_CYC);
			hps_pkg::ST_BIAS:    timer_load = 32'(BIAS_CYC);
			hps_pkg::ST_PDN:     timer_load = fast_pdn ? 32'(PD_FAST_CYC) : 32'(PD_CYC);
			hps_pkg::ST_GAP:     timer_load = 32'(OFF_CYC);
			default:             timer_load = 32'h0000_0000;
		endcase
		case (state_next)
			hps_pkg::ST_SWRST: cmd_next = '{hps_pkg::REG_SW_RESET, hps_pkg::VAL_SW_RESET};
			hps_pkg::ST_WAKE:  cmd_next = '{hps_pkg::REG_SLEEP, hps_pkg::VAL_WAKE};
			hps_pkg::ST_CFG:   cmd_next = hps_pkg::CFG_ROM[idx_next];
			hps_pkg::ST_DIAG:  cmd_next = '{hps_pkg::REG_DIAG_EN, hps_pkg::VAL_CH12_EN};
			default:           cmd_next = CMD_O;
		endcase
	end
	// state and wait timer; a wait is a full reload, but stop or supply loss can end it early, except in PDN and GAP
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			state_reg <= hps_pkg::ST_OFF;
			idx_reg   <= 3'h0;
			timer_reg <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
			idx_reg   <= idx_next;
			if (state_next != state_reg) begin
				timer_reg <= timer_load;
			end else if (!timer_done) begin
				timer_reg <= timer_reg - 32'h0000_0001;
			end
		end
	end
	// pin and command outputs, all registered from the next state
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			SUPPLY_EN_O  <= 1'b0;
			SHUTDOWN_N_O <= 1'b0;
			CMD_VALID_O  <= 1'b0;
			CMD_O        <= '0;
			CLOCKS_EN_O  <= 1'b0;
			RUNNING_O    <= 1'b0;
		end else begin
			SUPPLY_EN_O  <= (state_next != hps_pkg::ST_OFF) && (state_next != hps_pkg::ST_GAP);
			SHUTDOWN_N_O <= (state_next >= hps_pkg::ST_INIT) && (state_next <= hps_pkg::ST_RUN);
			CMD_VALID_O  <= (state_next == hps_pkg::ST_SWRST) || (state_next == hps_pkg::ST_WAKE) ||
				(state_next == hps_pkg::ST_CFG) || (state_next == hps_pkg::ST_DIAG);
			CMD_O        <= cmd_next;
			CLOCKS_EN_O  <= (state_next >= hps_pkg::ST_BIAS) && (state_next <= hps_pkg::ST_RUN);
			RUNNING_O    <= (state_next == hps_pkg::ST_RUN);
		end
	end

	// elapsed-time helpers watched by the checks below
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			since_ok_reg   <= 32'h0000_0000;
			since_rel_reg  <= 32'h0000_0000;
			since_shdn_reg <= 32'hFFFF_FFFF;
			since_off_reg  <= 32'hFFFF_FFFF;
			since_clk_reg  <= 32'h0000_0000;
		end else begin
			since_ok_reg   <= !supply_ok_s ? 32'h0000_0000 :
				since_ok_reg + 32'(since_ok_reg != 32'hFFFF_FFFF);
			since_rel_reg  <= ((state_next == hps_pkg::ST_INIT && state_reg != hps_pkg::ST_INIT) ||
				(state_reg == hps_pkg::ST_SWRST && accept)) ? 32'h0000_0000 :
				since_rel_reg + 32'(since_rel_reg != 32'hFFFF_FFFF);
			since_shdn_reg <= (SHUTDOWN_N_O && state_next == hps_pkg::ST_PDN) ? 32'h0000_0000 :
				since_shdn_reg + 32'(since_shdn_reg != 32'hFFFF_FFFF);
			since_off_reg  <= SUPPLY_EN_O ? 32'h0000_0000 :
				since_off_reg + 32'(since_off_reg != 32'hFFFF_FFFF);
			since_clk_reg  <= !CLOCKS_EN_O ? 32'h0000_0000 :
				since_clk_reg + 32'(since_clk_reg != 32'hFFFF_FFFF);
		end
	end
	property p_release_supply;
		@(posedge CLK_I) disable iff (!RESETN_I) $rose(SHUTDOWN_N_O) |-> supply_ok_s;
	endproperty
	a_release_supply: assert property (p_release_supply) else $error("release without supply");
	property p_settle;
		@(posedge CLK_I) disable iff (!RESETN_I) $rose(SHUTDOWN_N_O) |-> since_ok_reg >= SUPPLY_CYC;
	endproperty
	a_settle: assert property (p_settle) else $error("supply settle wait too short");
	property p_pdn_time;
		@(posedge CLK_I) disable iff (!RESETN_I)
			($fell(SUPPLY_EN_O) && !fast_pdn) |-> since_shdn_reg >= PD_CYC;
	endproperty
	a_pdn_time: assert property (p_pdn_time) else $error("supply dropped before 10 ms");
	property p_pdn_fast;
		@(posedge CLK_I) disable iff (!RESETN_I)
			($fell(SUPPLY_EN_O) && fast_pdn) |-> since_shdn_reg >= PD_FAST_CYC;
	endproperty
	a_pdn_fast: assert property (p_pdn_fast) else $error("supply dropped before 100 us");
	property p_off_gap;
		@(posedge CLK_I) disable iff (!RESETN_I) $rose(SUPPLY_EN_O) |-> since_off_reg >= OFF_CYC;
	endproperty
	a_off_gap: assert property (p_off_gap) else $error("power-up too soon after power-down");
	property p_swrst_first;
		@(posedge CLK_I) disable iff (!RESETN_I)
			(state_reg == hps_pkg::ST_INIT && state_next != hps_pkg::ST_INIT && SLOW_RAMP_I)
			|=> CMD_VALID_O && CMD_O.reg_addr == hps_pkg::REG_SW_RESET;
	endproperty
	a_swrst_first: assert property (p_swrst_first) else $error("first command not reset");
	property p_init_gap;
		@(posedge CLK_I) disable iff (!RESETN_I) $rose(CMD_VALID_O) |-> since_rel_reg >= INIT_CYC;
	endproperty
	a_init_gap: assert property (p_init_gap) else $error("command inside init window");
	property p_bus_idle;
		@(posedge CLK_I) disable iff (!RESETN_I)
			($rose(SHUTDOWN_N_O) && addr_high_s) |-> $past(scl_s && sda_s);
	endproperty
	a_bus_idle: assert property (p_bus_idle) else $error("bus busy at release");
	property p_bias;
		@(posedge CLK_I) disable iff (!RESETN_I)
			($rose(CMD_VALID_O) && CMD_O.reg_addr == hps_pkg::REG_DIAG_EN)
			|-> CLOCKS_EN_O && since_clk_reg >= BIAS_CYC;
	endproperty
	a_bias: assert property (p_bias) else $error("diagnostics enabled too early");
	property p_cmd_hold;
		@(posedge CLK_I) disable iff (!RESETN_I)
			(CMD_VALID_O && !CMD_READY_I) |=> CMD_VALID_O && $stable(CMD_O);
	endproperty
	a_cmd_hold: assert property (p_cmd_hold) else $error("command dropped before accept");
	property p_cfg_power;
		@(posedge CLK_I) disable iff (!RESETN_I)
			(accept && CMD_O.reg_addr == hps_pkg::REG_PWR_CFG) |=> !CMD_VALID_O ##1 CLOCKS_EN_O;
	endproperty
	a_cfg_power: assert property (p_cfg_power) else $error("clocks not started after power-up");
	c_run:      cover property (@(posedge CLK_I) disable iff (!RESETN_I) $rose(RUNNING_O));
	c_swrst:    cover property (@(posedge CLK_I) disable iff (!RESETN_I)
		accept && CMD_O.reg_addr == hps_pkg::REG_SW_RESET);
	c_fast_pdn: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
		$fell(SUPPLY_EN_O) && fast_pdn);
	c_idle_wait: cover property (@(posedge CLK_I) disable iff (!RESETN_I)
		state_reg == hps_pkg::ST_BUSIDLE ##1 state_reg == hps_pkg::ST_BUSIDLE);
endmodule

/* design/hps_sync3.sv */
/*
 * hps_sync3: three-flop input synchroniser; the output follows once the
 * second and third flops agree.
 * Assumes an asynchronous level input and a synchronous active-low reset.
 */
`timescale 1ns/100ps
module hps_sync3 #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic clk_i,
	input  wire logic resetn_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			s1_reg <= RESET_VAL;
			s2_reg <= RESET_VAL;
			s3_reg <= RESET_VAL;
			q_o    <= RESET_VAL;
		end else begin
			s1_reg <= d_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				q_o <= s3_reg;
			end
		end
	end
endmodule

/* include/hps_pkg.sv */
/*
 * hps_pkg: constants and types for the host-side power and bring-up sequencer
 * of a two-channel audio converter.
 * Assumes a 20 MHz sequencer clock; all waits are absolute minimum times.
 */
package hps_pkg;

	localparam int CLK_PERIOD_NS = 50;

	// minimum times, in ns
	localparam int T_SUPPLY_NS  = 100_000;
	localparam int T_INIT_NS    = 2_000_000;
	localparam int T_WAKE_NS    = 1_000_000;
	localparam int T_PD_NS      = 10_000_000;
	localparam int T_PD_FAST_NS = 100_000;
	localparam int T_OFF_NS     = 100_000_000;
	localparam int T_BIAS_NS    = 10_000_000;

	// minimum times round up to whole cycles
	localparam int T_SUPPLY_CYC  = (T_SUPPLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_INIT_CYC    = (T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_WAKE_CYC    = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_PD_CYC      = (T_PD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_PD_FAST_CYC = (T_PD_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_OFF_CYC     = (T_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_BIAS_CYC    = (T_BIAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// audio clock plan that the clock generator is asked for
	localparam int FRAME_SYNC_HZ    = 44_100;
	localparam int BIT_CLOCK_HZ     = 11_289_600;
	localparam int BCLK_PER_FRAME   = 256;
	localparam int CHANNEL_WORD_BITS = 32;

	// shutdown behaviour field value meaning immediate hardware shutdown
	localparam logic [1:0] SHDN_CFG_IMMEDIATE = 2'h0;

	// device register offsets and values
	localparam logic [7:0] REG_SW_RESET  = 8'h01;
	localparam logic [7:0] VAL_SW_RESET  = 8'h01;
	localparam logic [7:0] REG_SLEEP     = 8'h02;
	localparam logic [7:0] VAL_WAKE      = 8'h81;
	localparam logic [7:0] REG_CH1_CFG   = 8'h3C;
	localparam logic [7:0] REG_CH2_CFG   = 8'h41;
	localparam logic [7:0] VAL_CH_DIFF_HS = 8'h18;
	localparam logic [7:0] REG_IN_EN     = 8'h73;
	localparam logic [7:0] REG_SLOT_EN   = 8'h74;
	localparam logic [7:0] VAL_CH12_EN   = 8'hC0;
	localparam logic [7:0] REG_PWR_CFG   = 8'h75;
	localparam logic [7:0] VAL_PWR_UP    = 8'hE0;
	localparam logic [7:0] REG_DIAG_EN   = 8'h64;

	typedef struct packed {
		logic [7:0] reg_addr;
		logic [7:0] data;
	} hps_cmd_t;

	localparam int CFG_LEN = 5;
	localparam hps_cmd_t CFG_ROM [0:CFG_LEN-1] = '{
		'{REG_CH1_CFG, VAL_CH_DIFF_HS},
		'{REG_CH2_CFG, VAL_CH_DIFF_HS},
		'{REG_IN_EN,   VAL_CH12_EN},
		'{REG_SLOT_EN, VAL_CH12_EN},
		'{REG_PWR_CFG, VAL_PWR_UP}
	};

	typedef enum logic [3:0] {
		ST_OFF       = 4'h0,
		ST_PWR       = 4'h1,
		ST_SETTLE    = 4'h2,
		ST_BUSIDLE   = 4'h3,
		ST_INIT      = 4'h4,
		ST_SWRST     = 4'h5,
		ST_SWRST_W   = 4'h6,
		ST_WAKE      = 4'h7,
		ST_WAKE_W    = 4'h8,
		ST_CFG       = 4'h9,
		ST_BIAS      = 4'hA,
		ST_DIAG      = 4'hB,
		ST_RUN       = 4'hC,
		ST_PDN       = 4'hD,
		ST_GAP       = 4'hE
	} hps_state_t;

endpackage

/* verif/hps_dev_model.sv */
/*
 * hps_dev_model: stand-in for the converter and its control-bus master.
 * Assumes the bench clock and reset; stall_i and busy_i come from the bench.
 */
`timescale 1ns/100ps
module hps_dev_model #(
	parameter int INIT_CYC = 40
) (
	input  wire logic              clk_i,
	input  wire logic              resetn_i,
	input  wire logic              supply_en_i,
	input  wire logic              shutdown_n_i,
	input  wire logic              cmd_valid_i,
	input  wire hps_pkg::hps_cmd_t cmd_i,
	input  wire logic              stall_i,
	input  wire logic              busy_i,
	output logic                   supply_ok_o,
	output logic                   cmd_ready_o,
	output logic                   scl_o,
	output logic                   sda_o,
	output logic                   awake_o
);
	int   ramp_cnt;
	int   init_cnt;
	logic acc;

	assign acc = cmd_valid_i && cmd_ready_o;

	// supplies report good a while after enable
	always_ff @(posedge clk_i) begin
		ramp_cnt <= supply_en_i ? ramp_cnt + int'(ramp_cnt < 37) : 0;
	end
	assign supply_ok_o = supply_en_i && ramp_cnt >= 37;

	// pulled-up lines; a busy bus toggles clock and holds data low
	always_ff @(posedge clk_i) begin
		scl_o <= !(busy_i && scl_o === 1'b1);
	end
	assign sda_o = !busy_i;

	// bus master finishes a command after a random stall
	always_ff @(posedge clk_i) begin
		if (!resetn_i || acc)
			cmd_ready_o <= 1'b0;
		else if (cmd_valid_i && !stall_i)
			cmd_ready_o <= 1'b1;
	end

	// hardware shutdown while pin low; sleep until wake; wake writes lost during init
	always_ff @(posedge clk_i) begin
		if (!supply_ok_o || !shutdown_n_i) begin
			init_cnt <= 0;
			awake_o  <= 1'b0;
		end else if (acc && cmd_i == {hps_pkg::REG_SW_RESET, hps_pkg::VAL_SW_RESET}) begin
			init_cnt <= 0;
			awake_o  <= 1'b0;
		end else begin
			init_cnt <= init_cnt + int'(init_cnt < INIT_CYC);
			if (acc && init_cnt >= INIT_CYC && cmd_i == {hps_pkg::REG_SLEEP, hps_pkg::VAL_WAKE})
				awake_o <= 1'b1;
		end
	end
	// audio port runs as slave, so the early master frame sync never shows
endmodule

/* verif/hps_seq_top_tb.sv */
/*
 * hps_seq_top_tb: self-checking bench for the power and bring-up sequencer.
 * Assumes hps_dev_model as far side; long waits shortened by parameters.
 */
`timescale 1ns/100ps
module hps_seq_top_tb;
	localparam int INIT = 40;
	localparam int WAKE = 20;
	localparam int PD   = 60;
	localparam int OFF  = 80;
	localparam int BIAS = 50;

	logic CLK_I = 1'b0, RESETN_I = 1'b0, START_I = 1'b0, STOP_I = 1'b0;
	logic SLOW_RAMP_I = 1'b0, ADDR_HIGH_I = 1'b1, bus_busy = 1'b0, stall = 1'b0;
	logic [1:0] SHDN_CFG_I = 2'h1;
	logic SUPPLY_OK_I, SCL_I, SDA_I, CMD_READY_I, awake;
	logic SUPPLY_EN_O, SHUTDOWN_N_O, CMD_VALID_O, CLOCKS_EN_O, RUNNING_O;
	hps_pkg::hps_cmd_t CMD_O, last;
	logic [7:0]  rnd = 8'h47;
	logic [15:0] exp16;
	logic [15:0] expq[$];
	logic [1:0]  pd_cfg;
	logic p_shdn, p_sen, p_clk, p_ok;
	int cyc, t_ok, t_acc, t_clk, t_pdn, need, fail_count, total_checks;
	int t_off = -1;

	hps_seq_top #(.INIT_CYC(INIT), .WAKE_CYC(WAKE), .PD_CYC(PD), .OFF_CYC(OFF),
		.BIAS_CYC(BIAS)) uut (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .START_I(START_I),
		.STOP_I(STOP_I), .SLOW_RAMP_I(SLOW_RAMP_I), .SHDN_CFG_I(SHDN_CFG_I),
		.SUPPLY_OK_I(SUPPLY_OK_I), .ADDR_HIGH_I(ADDR_HIGH_I), .SCL_I(SCL_I),
		.SDA_I(SDA_I), .CMD_READY_I(CMD_READY_I), .SUPPLY_EN_O(SUPPLY_EN_O),
		.SHUTDOWN_N_O(SHUTDOWN_N_O), .CMD_VALID_O(CMD_VALID_O), .CMD_O(CMD_O),
		.CLOCKS_EN_O(CLOCKS_EN_O), .RUNNING_O(RUNNING_O));

	hps_dev_model #(.INIT_CYC(INIT)) dev (.clk_i(CLK_I), .resetn_i(RESETN_I),
		.supply_en_i(SUPPLY_EN_O), .shutdown_n_i(SHUTDOWN_N_O),
		.cmd_valid_i(CMD_VALID_O), .cmd_i(CMD_O), .stall_i(stall), .busy_i(bus_busy),
		.supply_ok_o(SUPPLY_OK_I), .cmd_ready_o(CMD_READY_I), .scl_o(SCL_I),
		.sda_o(SDA_I), .awake_o(awake));

	always #25 CLK_I = ~CLK_I;

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	always @(posedge CLK_I) begin
		rnd   <= lfsr(rnd);
		stall <= rnd[0] & rnd[1];
	end

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", what, e, g);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// reference model of pin order, command order and minimum spacing
	always @(posedge CLK_I) begin
		cyc++;
		if (RESETN_I) begin
			if (SHUTDOWN_N_O && !SUPPLY_OK_I)
				chk("pin vs supply", 0, 1);
			if (SHUTDOWN_N_O && !p_shdn) begin
				chk("settle", 1, cyc - t_ok >= 2000);
				chk("bus idle", 1, !ADDR_HIGH_I || (SCL_I && SDA_I));
				t_acc = cyc;
				need  = INIT;
			end
			if (CMD_VALID_O && CMD_READY_I) begin
				exp16 = expq.size() ? expq.pop_front() : 16'hxxxx;
				chk("command", exp16, CMD_O);
				chk("cmd spacing", 1, cyc - t_acc >= need);
				if (CMD_O === 16'h64c0)
					chk("bias wait", 1, cyc - t_clk >= BIAS);
				need  = CMD_O === 16'h0101 ? INIT : CMD_O === 16'h0281 ? WAKE : 0;
				t_acc = cyc;
				last  = CMD_O;
			end
			if (CLOCKS_EN_O && !p_clk) begin
				t_clk = cyc;
				chk("clock start", 16'h75e0, last);
			end
			if (!SHUTDOWN_N_O && p_shdn) begin
				t_pdn  = cyc;
				pd_cfg = SHDN_CFG_I;
			end
			if (!SUPPLY_EN_O && p_sen) begin
				chk("supply hold", 1, cyc - t_pdn >= (pd_cfg == 2'h0 ? 2000 : PD));
				t_off = cyc;
			end
			if (SUPPLY_EN_O && !p_sen && t_off >= 0)
				chk("off gap", 1, cyc - t_off >= OFF);
		end
		if (SUPPLY_OK_I && !p_ok)
			t_ok = cyc;
		p_shdn = SHUTDOWN_N_O;
		p_sen  = SUPPLY_EN_O;
		p_clk  = CLOCKS_EN_O;
		p_ok   = SUPPLY_OK_I;
	end

	task automatic wait_for(input string what, ref logic sig, input logic val);
		int n;
		n = 0;
		while (sig !== val && n < 20000) begin
			@(negedge CLK_I);
			n++;
		end
		chk(what, val, sig);
	endtask

	task automatic bring_up(input logic slow, input logic busy, input logic addr);
		@(posedge CLK_I);
		SLOW_RAMP_I <= slow;
		ADDR_HIGH_I <= addr;
		bus_busy    <= busy;
		START_I     <= 1'b1;
		expq = '{16'h3c18, 16'h4118, 16'h73c0, 16'h74c0, 16'h75e0, 16'h64c0};
		expq.push_front({hps_pkg::REG_SLEEP, hps_pkg::VAL_WAKE});
		if (slow)
			expq.push_front(16'h0101);
		wait_for("supply on", SUPPLY_EN_O, 1'b1);
		@(posedge CLK_I);
		START_I <= 1'b0;
		if (busy) begin
			repeat (3000) @(posedge CLK_I);
			chk("held in shutdown", !addr, SHUTDOWN_N_O);
			bus_busy <= 1'b0;
		end
		wait_for("running", RUNNING_O, 1'b1);
		chk("commands left", 0, expq.size());
		chk("clocks on", 1, CLOCKS_EN_O);
		chk("device awake", 1, awake);
	endtask

	task automatic shut_down(input logic [1:0] cfg);
		@(posedge CLK_I);
		SHDN_CFG_I <= cfg;
		STOP_I     <= 1'b1;
		wait_for("supply off", SUPPLY_EN_O, 1'b0);
		chk("pin low", 0, SHUTDOWN_N_O);
		chk("device down", 0, awake);
		@(posedge CLK_I);
		STOP_I <= 1'b0;
	endtask

	initial begin
		repeat (10) @(posedge CLK_I);
		RESETN_I <= 1'b1;
		@(negedge CLK_I);
		chk("reset outputs", 0, {SUPPLY_EN_O, SHUTDOWN_N_O, CMD_VALID_O, CLOCKS_EN_O});
		bring_up(1'b0, 1'b1, 1'b1);
		shut_down(2'h1);
		bring_up(1'b1, 1'b0, 1'b1);
		shut_down(2'h0);
		bring_up(1'b0, 1'b1, 1'b0);
		shut_down(2'h3);
		complete_run();
	end

	initial begin
		repeat (40000) @(posedge CLK_I);
		fail_count++;
		complete_run();
	end
endmodule
